// ==== design/reference_control_pkg.sv ====
package reference_control_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] REFERENCE_CONTROL_OFFSET = 12'h90C;
    localparam logic [7:0]  REFERENCE_CONTROL_RESET  = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int REFERENCE_ENABLE_BIT      = 7;
    localparam int REFERENCE_READY_BIT       = 6;
    localparam int TEMP_INDICATOR_ENABLE_BIT = 5;
    localparam int TEMP_INDICATOR_RANGE_BIT  = 4;
    localparam int COMPARATOR_GAIN_LSB       = 2;
    localparam int CONVERTER_GAIN_LSB        = 0;

    // ready flag value, fixed in this device
    localparam logic READY_FLAG_VALUE = 1'b1;

    // ------------------------------------------------------------
    // buffer gain encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        buffer_off = 2'h0,
        gain_1x    = 2'h1,
        gain_2x    = 2'h2,
        gain_4x    = 2'h3
    } buffer_gain_type;

endpackage : reference_control_pkg

// ==== design/reference_control.sv ====
// Contract
// RQ1 - reference is enabled while bit 7 is one, disabled while zero
// RQ2 - read-only bit 6 reports reference readiness
// RQ3 - ready flag always reads one in this device
// RQ4 - temperature indicator enabled while bit 5 is one
// RQ5 - bit 4 selects high range (four drops) or low range (two drops)
// RQ6 - bits 3:2 set comparator buffer gain 4x/2x/1x, or off for 00
// RQ7 - bits 1:0 set converter buffer gain 4x/2x/1x, or off for 00
// RQ8 - the two buffers have independent gain and enable
// RQ9 - 8-bit register at 0x90C, resets to zero, ready flag read-only
// RQ10 - writes to the ready flag position are ignored
//
// The APB register port was decided locally.
`timescale 1ns/10ps

module reference_control (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [11:0]                            paddr,
    input  wire logic [31:0]                            pwdata,
    input  wire logic [3:0]                             pstrb,
    output logic      [31:0]                            prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    output logic                                        reference_enable,
    output logic                                        temp_indicator_enable,
    output logic                                        temp_indicator_range,
    output reference_control_pkg::buffer_gain_type      comparator_buffer_gain,
    output logic                                        comparator_buffer_on,
    output reference_control_pkg::buffer_gain_type      converter_buffer_gain,
    output logic                                        converter_buffer_on
);
    import reference_control_pkg::*;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [7:0]  control_q;             // stored fields, ready position held at zero
    logic [7:0]  control_d;
    logic [7:0]  read_value;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    wire         hit;
    wire         setup_read;
    wire         access_write;
    wire         lane0_write;
    wire         enable_wr;
    wire         temp_enable_wr;
    wire         temp_range_wr;
    wire   [1:0] comparator_gain_wr;
    wire   [1:0] converter_gain_wr;
    wire   [7:0] write_image;
    wire  [31:0] read_word;

    // exact match of all twelve address bits on the single register
    assign hit          = (paddr == REFERENCE_CONTROL_OFFSET);
    assign setup_read   = psel && !penable && !pwrite;
    assign lane0_write  = pstrb[0];         // only byte lane 0 holds the register
    assign access_write = psel && penable && pwrite && hit && lane0_write;

    // ------------------------------------------------------------
    // bus response
    // ------------------------------------------------------------
    // every access completes in its first access cycle
    assign pready       = 1'b1;             // zero wait states
    assign pslverr      = 1'b0;             // unmapped: reads zero, writes dropped

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    // writable fields picked out of the write data
    assign enable_wr          = pwdata[REFERENCE_ENABLE_BIT];
    assign temp_enable_wr     = pwdata[TEMP_INDICATOR_ENABLE_BIT];
    assign temp_range_wr      = pwdata[TEMP_INDICATOR_RANGE_BIT];
    assign comparator_gain_wr = pwdata[COMPARATOR_GAIN_LSB +: 2];
    assign converter_gain_wr  = pwdata[CONVERTER_GAIN_LSB +: 2];

    // ready position stored as zero, whatever the bus writes
    assign write_image = {enable_wr, 1'b0, temp_enable_wr, temp_range_wr,
                          comparator_gain_wr, converter_gain_wr};       // see RQ10

    // register keeps its value unless a write lands
    assign control_d = access_write ? write_image : control_q;          // see RQ9

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // read image: ready flag fixed at one
    always_comb begin
        read_value = control_q;
        read_value[REFERENCE_READY_BIT] = READY_FLAG_VALUE; // see RQ2 see RQ3
    end

    // unmapped addresses read as zero
    assign read_word = hit ? {24'h000000, read_value} : 32'h00000000;  // see RQ9

    // read data captured in setup, stable through access
    assign prdata_d = setup_read ? read_word : prdata_q;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // control register, all fields zero at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q <= REFERENCE_CONTROL_RESET; // see RQ9
        end else begin
            control_q <= control_d;
        end
    end

    // read data holding register, cleared at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else begin
            prdata_q <= prdata_d;
        end
    end

    // read data leaves a flip-flop
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------
    // enables and range straight from the stored fields
    assign reference_enable       = control_q[REFERENCE_ENABLE_BIT];      // see RQ1
    assign temp_indicator_enable  = control_q[TEMP_INDICATOR_ENABLE_BIT]; // see RQ4
    assign temp_indicator_range   = control_q[TEMP_INDICATOR_RANGE_BIT];  // see RQ5

    // ------------------------------------------------------------
    // buffer gain stages
    // ------------------------------------------------------------
    // comparator and dac buffer, its own field and enable
    buffer_gain_stage #(
        .LSB          (COMPARATOR_GAIN_LSB)
    ) i_buffer_gain_stage_comparator (
        .pclk         (pclk),
        .presetn      (presetn),
        .control_now  (control_q),
        .control_next (control_d),
        .gain         (comparator_buffer_gain),     // see RQ6 see RQ8
        .buffer_on    (comparator_buffer_on)        // see RQ6
    );

    // converter buffer, same stage on the low field
    buffer_gain_stage #(
        .LSB          (CONVERTER_GAIN_LSB)
    ) i_buffer_gain_stage_converter (
        .pclk         (pclk),
        .presetn      (presetn),
        .control_now  (control_q),
        .control_next (control_d),
        .gain         (converter_buffer_gain),      // see RQ7 see RQ8
        .buffer_on    (converter_buffer_on)         // see RQ7
    );

endmodule : reference_control

// ------------------------------------------------------------
// one buffer gain stage
// ------------------------------------------------------------
// gain code and on flag of one two-bit buffer field; one instance
// per buffer, so the two paths never share state
module buffer_gain_stage #(
    parameter int LSB = 0
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic [7:0]                           control_now,
    input  wire logic [7:0]                           control_next,
    output reference_control_pkg::buffer_gain_type    gain,
    output logic                                      buffer_on
);
    import reference_control_pkg::*;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    logic       on_q;
    logic       on_d;
    wire  [1:0] field_now;
    wire  [1:0] field_next;

    // this stage's slice of the stored and the next register value
    assign field_now  = control_now[LSB +: 2];
    assign field_next = control_next[LSB +: 2];

    // gain code straight from the stored field
    assign gain = buffer_gain_type'(field_now);

    // code 00 turns the buffer off; decoded one cycle ahead so the
    // flag leaves a flip-flop in step with the gain code
    assign on_d = (field_next != buffer_off);

    // ------------------------------------------------------------
    // on flag
    // ------------------------------------------------------------
    // off at reset, like the field it mirrors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_q <= 1'b0;
        end else begin
            on_q <= on_d;
        end
    end

    // flag leaves a flip-flop
    assign buffer_on = on_q;

endmodule : buffer_gain_stage

// ==== tb/reference_control_properties.sv ====
`timescale 1ns/10ps
module reference_control_properties import reference_control_pkg::*; (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    input wire logic reference_enable, temp_indicator_enable, temp_indicator_range,
    input wire logic comparator_buffer_on, converter_buffer_on,
    input wire buffer_gain_type comparator_buffer_gain, converter_buffer_gain
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // one write access, and a read setup followed by its access
    sequence wr; psel && penable && pwrite && paddr == 12'h90C && pstrb[0]; endsequence
    sequence rd; psel && !penable && !pwrite && paddr == 12'h90C ##1 penable; endsequence
    chk_ref_enable:
        assert property (wr |=> reference_enable == $past(pwdata[7])) else $error("enable");
    chk_temp_enable:
        assert property (wr |=> temp_indicator_enable == $past(pwdata[5])) else $error("temp");
    chk_temp_range:
        assert property (wr |=> temp_indicator_range == $past(pwdata[4])) else $error("range");
    chk_comp_gain:
        assert property (wr |=> comparator_buffer_gain == $past(pwdata[3:2])
            && comparator_buffer_on == |$past(pwdata[3:2])) else $error("comp gain");
    chk_conv_gain:
        assert property (wr |=> converter_buffer_gain == $past(pwdata[1:0])
            && converter_buffer_on == |$past(pwdata[1:0])) else $error("conv gain");
    chk_read_value:
        assert property (rd |-> prdata == {24'h0, $past(reference_enable), 1'b1,
            $past({temp_indicator_enable, temp_indicator_range, comparator_buffer_gain,
            converter_buffer_gain})}) else $error("read value");
    chk_unmapped_zero:
        assert property (psel && !penable && !pwrite && paddr != 12'h90C |=> prdata == 32'h0)
            else $error("unmapped read");
    chk_no_wait:
        assert property (psel && penable |-> pready && !pslverr) else $error("wait");
endmodule : reference_control_properties
bind reference_control reference_control_properties i_reference_control_properties (.*);

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    import reference_control_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    logic reference_enable, temp_indicator_enable, temp_indicator_range;
    logic comparator_buffer_on, converter_buffer_on;
    buffer_gain_type comparator_buffer_gain, converter_buffer_gain;
    int num_errors = 0, checked = 0;
    // write address, data, strobes and the byte expected back
    logic [11:0] wa[6] = '{12'h908, 12'h90C, 12'h90C, 12'h90C, 12'h90C, 12'h90C};
    logic [7:0] wd[6] = '{8'hFF, 8'hFF, 8'h00, 8'h99, 8'h26, 8'h7F};
    logic [3:0] ws[6] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hE};
    logic [7:0] ex[6] = '{8'h40, 8'hFF, 8'h40, 8'hD9, 8'h66, 8'h66};
    always #5 pclk = ~pclk;
    reference_control i_reference_control (.*);
    // one apb transfer, then an idle cycle
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata; psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] v);
        checked++;
        if (v !== e) begin num_errors++; $display("unexpected %s: %h seen %h", n, e, v); end
    endtask : cmp
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (wa[i]) begin
            bus(1'b1, wa[i], {24'h0, wd[i]}, ws[i]);
            bus(1'b0, 12'h90C, 32'h0, 4'h0);
            cmp("read", {24'h0, ex[i]}, q);
            cmp("pins", {ex[i][7], ex[i][5:0], |ex[i][3:2], |ex[i][1:0]},
                {reference_enable, temp_indicator_enable, temp_indicator_range,
                 comparator_buffer_gain, converter_buffer_gain, comparator_buffer_on,
                 converter_buffer_on});
            $display("test %0d done", i);
        end
        // mid-run reset clears every writable field
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        bus(1'b0, 12'h90C, 32'h0, 4'h0);
        cmp("reset read", 32'h00000040, q);
        cmp("reset pins", 32'h0, {reference_enable, temp_indicator_enable, temp_indicator_range,
            comparator_buffer_gain, converter_buffer_gain, comparator_buffer_on,
            converter_buffer_on});
        $display("test reset done");
        bus(1'b0, 12'h908, 32'h0, 4'h0);
        cmp("unmapped", 32'h0, q);
        finish_test;
    end
    initial begin #5000; num_errors++; finish_test; end
endmodule : tb
